//--- rtl/dio_pkg.sv
package dio_pkg;
    // ==========================================================
    // Port widths
    localparam int N_IN = 8;
    localparam int N_OUT = 8;
    localparam int CFG_W = 16;

    // ==========================================================
    // Time base
    localparam int CLK_MHZ = 200;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
    localparam int TICK_CNT_W = 18;
    localparam int RES_MS = 10;
    localparam logic [3:0] RES_MS_M1 = 4'h9;

    // ==========================================================
    // Reset values
    localparam logic [7:0] OUT_RESET = 8'h00;
    localparam logic [7:0] IN_RESET = 8'h00;
endpackage

//--- rtl/dio_tick_if.sv
interface dio_tick_if;
    logic tick_10ms;
    modport src (output tick_10ms);
    modport dst (input tick_10ms);
endinterface

//--- rtl/dio_tick_gen.sv
module dio_tick_gen #(
    parameter int TICK_CYCLES = dio_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic rst_sync_b,
    dio_tick_if.src tick
);
    logic [dio_pkg::TICK_CNT_W-1:0] cycle_cnt;
    logic [3:0] ms_cnt;
    logic ms_pulse;

    // ==========================================================
    // Millisecond divider
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            cycle_cnt <= '0;
            ms_pulse <= 1'b0;
        end
        else if (cycle_cnt == dio_pkg::TICK_CNT_W'(TICK_CYCLES - 1))
        begin
            cycle_cnt <= '0;
            ms_pulse <= 1'b1;
        end
        else
        begin
            cycle_cnt <= cycle_cnt + 1'b1;
            ms_pulse <= 1'b0;
        end
    end

    // ==========================================================
    // Ten millisecond resolution tick
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            ms_cnt <= '0;
            tick.tick_10ms <= 1'b0;
        end
        else
        begin
            tick.tick_10ms <= 1'b0;
            if (ms_pulse)
            begin
                if (ms_cnt == dio_pkg::RES_MS_M1)
                begin
                    ms_cnt <= '0;
                    tick.tick_10ms <= 1'b1;
                end
                else
                begin
                    ms_cnt <= ms_cnt + 1'b1;
                end
            end
        end
    end
endmodule

//--- rtl/dio_port.sv
// Operation
// - Input level accepted only after staying stable for the qualification time.
// - Qualification time set in 1ms, applied truncated to 10ms steps.
// - Commanded outputs drive pins only after the output delay elapses.
// - Zero output delay applies commanded values immediately.
// - Output delay set in 1ms, timed truncated to 10ms steps.
// - Output commands arriving while the delay runs are discarded.
// - With reporting enabled, any qualified input change raises an unsolicited report.
module dio_port #(
    parameter int TICK_CYCLES = dio_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [dio_pkg::N_IN-1:0] in_pin,
    input wire logic [dio_pkg::CFG_W-1:0] valid_time_ms,
    input wire logic [dio_pkg::CFG_W-1:0] out_delay_ms,
    input wire logic notify_en,
    input wire logic out_cmd_valid,
    input wire logic [dio_pkg::N_OUT-1:0] out_cmd_data,
    output logic out_cmd_taken,
    output logic out_cmd_dropped,
    output logic [dio_pkg::N_OUT-1:0] out_pin,
    output logic [dio_pkg::N_IN-1:0] in_state,
    output logic delay_busy,
    output logic notify_req
);
    typedef enum logic [1:0] {
        IDLE = 2'b01,
        WAIT = 2'b10
    } dio_out_e;

    logic rst_meta_b;
    logic rst_sync_b;
    logic [dio_pkg::N_IN-1:0] in_meta;
    logic [dio_pkg::N_IN-1:0] in_sync;
    logic [dio_pkg::CFG_W-1:0] valid_ticks;
    logic [dio_pkg::CFG_W-1:0] delay_ticks;
    logic [dio_pkg::N_IN-1:0] in_changed;
    logic [dio_pkg::CFG_W-1:0] delay_cnt;
    logic [dio_pkg::N_OUT-1:0] pend_data;
    logic delay_done;
    dio_out_e out_state;
    dio_tick_if tick_bus ();

    // ==========================================================
    // Reset release
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // Pin synchroniser
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            in_meta <= dio_pkg::IN_RESET;
            in_sync <= dio_pkg::IN_RESET;
        end
        else
        begin
            in_meta <= in_pin;
            in_sync <= in_meta;
        end
    end

    dio_tick_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clock(clock),
        .rst_sync_b(rst_sync_b),
        .tick(tick_bus.src)
    );

    // ==========================================================
    // Truncate millisecond settings to 10ms tick counts
    assign valid_ticks = valid_time_ms / dio_pkg::CFG_W'(dio_pkg::RES_MS);
    assign delay_ticks = out_delay_ms / dio_pkg::CFG_W'(dio_pkg::RES_MS);

    // ==========================================================
    // Per-input qualification
    genvar gi;
    generate
        for (gi = 0; gi < dio_pkg::N_IN; gi++)
        begin : g_in
            logic [dio_pkg::CFG_W-1:0] stable_cnt;

            // Restart while pin matches accepted state, accept once it has differed long enough
            always_ff @(posedge clock or negedge rst_sync_b)
            begin
                if (!rst_sync_b)
                begin
                    stable_cnt <= '0;
                    in_state[gi] <= dio_pkg::IN_RESET[gi];
                    in_changed[gi] <= 1'b0;
                end
                else
                begin
                    in_changed[gi] <= 1'b0;
                    if (in_sync[gi] == in_state[gi])
                    begin
                        stable_cnt <= '0;
                    end
                    else if (stable_cnt >= valid_ticks)
                    begin
                        in_state[gi] <= in_sync[gi];
                        in_changed[gi] <= 1'b1;
                        stable_cnt <= '0;
                    end
                    else if (tick_bus.tick_10ms)
                    begin
                        stable_cnt <= stable_cnt + 1'b1;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Unsolicited report event from qualified changes
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            notify_req <= 1'b0;
        end
        else
        begin
            notify_req <= notify_en && (|in_changed);
        end
    end

    // ==========================================================
    // Output delay machine
    assign out_cmd_taken = out_cmd_valid && (out_state == IDLE);
    assign out_cmd_dropped = out_cmd_valid && (out_state == WAIT);
    assign delay_busy = (out_state == WAIT);
    assign delay_done = (out_state == WAIT) && tick_bus.tick_10ms && (delay_cnt == dio_pkg::CFG_W'(1));

    // Timer state: idle or counting down
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            out_state <= IDLE;
        end
        else
        begin
            unique case (out_state)
                IDLE:
                begin
                    if (out_cmd_valid && (delay_ticks != '0))
                    begin
                        out_state <= WAIT;
                    end
                end
                WAIT:
                begin
                    // Commands here are dropped; only the timer ends the wait
                    if (delay_done)
                    begin
                        out_state <= IDLE;
                    end
                end
                default:
                begin
                    out_state <= IDLE;
                end
            endcase
        end
    end

    // Delay countdown in 10ms ticks, loaded at acceptance
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            delay_cnt <= '0;
        end
        else if (out_cmd_taken)
        begin
            delay_cnt <= delay_ticks;
        end
        else if (delay_busy && tick_bus.tick_10ms)
        begin
            delay_cnt <= delay_cnt - 1'b1;
        end
    end

    // Pending value, only from accepted commands
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            pend_data <= dio_pkg::OUT_RESET;
        end
        else if (out_cmd_taken)
        begin
            pend_data <= out_cmd_data;
        end
    end

    // Output port register
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            out_pin <= dio_pkg::OUT_RESET;
        end
        else if (out_cmd_taken && (delay_ticks == '0))
        begin
            out_pin <= out_cmd_data;
        end
        else if (delay_done)
        begin
            out_pin <= pend_data;
        end
    end
endmodule

//--- test/dio_port_chk.sv
module dio_port_chk (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [dio_pkg::N_IN-1:0] in_pin,
    input wire logic [dio_pkg::CFG_W-1:0] out_delay_ms,
    input wire logic notify_en,
    input wire logic out_cmd_valid,
    input wire logic [dio_pkg::N_OUT-1:0] out_cmd_data,
    input wire logic out_cmd_taken,
    input wire logic out_cmd_dropped,
    input wire logic [dio_pkg::N_OUT-1:0] out_pin,
    input wire logic [dio_pkg::N_IN-1:0] in_state,
    input wire logic delay_busy,
    input wire logic notify_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [dio_pkg::N_OUT-1:0] last_taken;
    // =====
    // Port timing checks
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Data of the last accepted command
    always_ff @(posedge clock)
    begin
        if (out_cmd_taken)
        begin
            last_taken <= out_cmd_data;
        end
    end
    sequence s_delay_end;
        $fell(delay_busy);
    endsequence
    applied_value_a: assert property (s_delay_end |-> out_pin == last_taken)
        else $error("output not from accepted command");
    sequence s_in_moved;
        notify_en && $changed(in_state);
    endsequence
    sequence s_report;
        notify_req;
    endsequence
    drop_when_busy_a: assert property (out_cmd_valid && delay_busy |-> out_cmd_dropped && !out_cmd_taken)
        else $error("command not dropped while busy");
    take_when_idle_a: assert property (out_cmd_valid && !delay_busy |-> out_cmd_taken && !out_cmd_dropped)
        else $error("command not taken while idle");
    zero_delay_a: assert property (out_cmd_taken && out_delay_ms < 16'h000A |=> out_pin == $past(out_cmd_data))
        else $error("zero delay output not applied");
    busy_start_a: assert property (out_cmd_taken && out_delay_ms >= 16'h000A |=> delay_busy)
        else $error("delay timer not started");
    out_cause_a: assert property ($changed(out_pin) |-> $past(out_cmd_taken) || $fell(delay_busy))
        else $error("output changed without cause");
    change_report_a: assert property (s_in_moved |=> s_report)
        else $error("input change not reported");
    report_cause_a: assert property (notify_req |-> $past(notify_en) && $past(in_state) != $past(in_state, 2))
        else $error("report without qualified change");
    qual_level_a: assert property ($changed(in_state)
        |-> ((in_state ^ $past(in_state)) & (in_state ^ $past(in_pin, 3))) == 8'h00)
        else $error("input state not from stable pin");
endmodule

bind dio_port dio_port_chk chk (.clock, .rst_b, .in_pin, .out_delay_ms, .notify_en, .out_cmd_valid,
    .out_cmd_data, .out_cmd_taken, .out_cmd_dropped, .out_pin, .in_state, .delay_busy, .notify_req);

//--- test/dio_master_model.sv
module dio_master_model (
    input wire logic clock,
    input wire logic notify_req,
    input wire logic [dio_pkg::N_IN-1:0] in_state,
    output logic [dio_pkg::N_IN-1:0] seen,
    output int reports
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====
    // Network master logging unsolicited reports
    int count = 0;
    assign reports = count;
    always @(posedge clock)
        if (notify_req === 1'b1)
        begin
            seen <= in_state;
            count <= count + 1;
        end
endmodule

//--- test/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_b, nen, ov, tk, dr, busy, nreq;
    logic [7:0] pin, od, opin, ist, seen;
    logic [15:0] valt, odly;
    int err_count, cmp_count, reports, n, r;
    dio_port #(.TICK_CYCLES(4)) dut (.clock, .rst_b, .in_pin(pin), .valid_time_ms(valt), .out_delay_ms(odly),
        .notify_en(nen), .out_cmd_valid(ov), .out_cmd_data(od), .out_cmd_taken(tk), .out_cmd_dropped(dr),
        .out_pin(opin), .in_state(ist), .delay_busy(busy), .notify_req(nreq));
    dio_master_model master (.clock, .notify_req(nreq), .in_state(ist), .seen, .reports);
    // =====
    // Clock and helpers
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic print_verdict;
        if (err_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(string name, logic [15:0] got, logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic step(int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic send(logic [7:0] d, logic exp_tk);
        ov = 1'b1;
        od = d;
        #1;
        check("taken", tk, exp_tk);
        check("dropped", dr, !exp_tk);
        step(1);
        ov = 1'b0;
    endtask
    // =====
    // Scenarios
    task automatic t_glitch;
        r = reports;
        pin = 8'h01;
        step(10);
        pin = 8'h00;
        step(150);
        check("in_state", ist, 8'h00);
        check("reports", reports - r, 0);
    endtask
    task automatic t_qual;
        r = reports;
        pin = 8'hA5;
        for (n = 0; n < 200 && ist !== 8'hA5; n++) step(1);
        check("qual_cycles", 16'(n >= 44 && n <= 83), 1);
        step(3);
        check("report", seen, 8'hA5);
        check("reports", reports - r, 1);
        nen = 1'b0;
        pin = 8'h00;
        step(120);
        check("in_state", ist, 8'h00);
        check("reports", reports - r, 1);
    endtask
    task automatic t_out;
        send(8'h3C, 1'b1);
        check("out_pin", opin, 8'h3C);
        odly = 16'h0007;
        step(1);
        send(8'hC3, 1'b1);
        check("out_pin", opin, 8'hC3);
        odly = 16'h001D;
        step(1);
        send(8'h5A, 1'b1);
        check("busy", busy, 1);
        step(1);
        send(8'h99, 1'b0);
        for (n = 3; n < 200 && opin !== 8'h5A; n++) step(1);
        check("delay_cycles", 16'(n >= 42 && n <= 81), 1);
        step(10);
        check("out_pin", opin, 8'h5A);
    endtask
    // =====
    // Main sequence and watchdog
    initial
    begin
        rst_b = 1'b0;
        nen = 1'b1;
        ov = 1'b0;
        od = 8'h00;
        pin = 8'h00;
        valt = 16'h0019;
        odly = 16'h0000;
        err_count = 0;
        cmp_count = 0;
        repeat (2) @(posedge clock);
        #1;
        rst_b = 1'b1;
        step(3);
        t_glitch;
        t_qual;
        t_out;
        print_verdict;
    end
    initial
    begin
        repeat (3000) @(posedge clock);
        err_count++;
        print_verdict;
    end
endmodule
